//--- common/dtc_map.vh
// Purpose: Register offsets, field positions and reset values of the dual timer/counter
// Assumes: Byte-wide registers on an 8-bit address port
// Notes:   Definitions only
`ifndef DTC_MAP_VH
`define DTC_MAP_VH

`define DTC_ADDR_W          8
`define DTC_OFS_CTRL        8'h88
`define DTC_OFS_MODE        8'h89
`define DTC_OFS_CNT_LO_A    8'h8A
`define DTC_OFS_CNT_LO_B    8'h8B
`define DTC_OFS_CNT_HI_A    8'h8C
`define DTC_OFS_CNT_HI_B    8'h8D
`define DTC_OFS_CTRL_B      8'h91
`define DTC_OFS_RLD_LO_A    8'h92
`define DTC_OFS_RLD_LO_B    8'h93
`define DTC_OFS_RLD_HI_A    8'h94
`define DTC_OFS_RLD_HI_B    8'h95
`define DTC_OFS_PRESCALE    8'h96

`define DTC_CTRL_OVF_B      7
`define DTC_CTRL_RUN_B      6
`define DTC_CTRL_OVF_A      5
`define DTC_CTRL_RUN_A      4

`define DTC_MODE_GATE_B     7
`define DTC_MODE_FUNC_B     6
`define DTC_MODE_FIELD_B    5:4
`define DTC_MODE_GATE_A     3
`define DTC_MODE_FUNC_A     2
`define DTC_MODE_FIELD_A    1:0

`define DTC_CTRLB_PWM       7:6
`define DTC_CTRLB_PSC_B     5:3
`define DTC_CTRLB_PSC_A     2:0

`define DTC_PRE_VALUE       3:0
`define DTC_PRE_RC_OSC      4

`define DTC_RST_CTRL        8'h00
`define DTC_RST_MODE        8'h00
`define DTC_RST_CTRL_B      8'h24
`define DTC_RST_BYTE        8'h00
`define DTC_RST_PRESCALE    5'h00

`define DTC_MODE_VARIABLE   2'h0
`define DTC_MODE_RELOAD16   2'h1
`define DTC_MODE_RELOAD8    2'h2
`define DTC_MODE_STOPPED    2'h3

`endif

//--- design/dtc_timer.v
// Purpose: Two 16-bit timer/counters with shared prescaler and three counting modes
// Assumes: One clock sys_clk, synchronous active-low reset, byte register port
// Notes:   Split mode is not provided; mode 3 holds the count
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "dtc_map.vh"

module dtc_timer #(
    parameter PIN_COUNT = 1
) (
    input  wire       sys_clk,
    input  wire       reset_n,
    input  wire [7:0] regAddr,
    input  wire [7:0] regWrData,
    input  wire       regWrite,
    input  wire       regRead,
    output reg  [7:0] regRdData_q,
    input  wire       countInputA,
    input  wire       countInputB,
    input  wire       gateInputA,
    input  wire       gateInputB,
    input  wire       port3LatchA,
    input  wire       port3LatchB,
    input  wire       intAckA,
    input  wire       intAckB,
    output reg        overflowFlagA_q,
    output reg        overflowFlagB_q
);

    // Next {flag, high, low} for one timer given one count pulse
    function [16:0] dtcStep;
        input [1:0] mode;
        input [2:0] psc;
        input [7:0] hi;
        input [7:0] lo;
        input [7:0] rldHi;
        input [7:0] rldLo;
        reg   [7:0] mask;
        reg   [7:0] loInc;
        begin
            mask  = 8'hFF >> (3'h7 - psc);
            loInc = lo + 8'h01;
            dtcStep = {1'b0, hi, lo};
            case (mode)
                `DTC_MODE_VARIABLE: begin
                    // Bits above the field keep their value; software ignores them
                    if ((lo & mask) == mask) begin
                        dtcStep = {(hi == 8'hFF), hi + 8'h01, lo & ~mask};
                    end else begin
                        dtcStep = {1'b0, hi, (lo & ~mask) | (loInc & mask)};
                    end
                end
                `DTC_MODE_RELOAD16: begin
                    if ({hi, lo} == 16'hFFFF) begin
                        dtcStep = {1'b1, rldHi, rldLo};
                    end else begin
                        dtcStep = {1'b0, {hi, lo} + 16'h0001};
                    end
                end
                `DTC_MODE_RELOAD8: begin
                    if (lo == 8'hFF) begin
                        dtcStep = {1'b1, hi, hi};
                    end else begin
                        dtcStep = {1'b0, hi, loInc};
                    end
                end
                default: begin
                    dtcStep = {1'b0, hi, lo};
                end
            endcase
        end
    endfunction

    reg  [7:0] ctrlReg_q;
    reg  [7:0] modeReg_q;
    reg  [7:0] ctrlRegB_q;
    reg  [4:0] prescaleReg_q;
    reg  [7:0] cntLoA_q;
    reg  [7:0] cntHiA_q;
    reg  [7:0] cntLoB_q;
    reg  [7:0] cntHiB_q;
    reg  [7:0] rldLoA_q;
    reg  [7:0] rldHiA_q;
    reg  [7:0] rldLoB_q;
    reg  [7:0] rldHiB_q;
    reg  [3:0] preCnt_q;
    reg  [3:0] pinSync1_q;
    reg  [3:0] pinSync2_q;
    reg  [3:0] pinSync3_q;
    reg  [3:0] pinFilt_q;
    reg  [1:0] cntPrev_q;

    wire       runA;
    wire       runB;
    wire       preTick;
    wire [1:0] cntLevel;
    wire [1:0] cntFall;
    wire       gateOkA;
    wire       gateOkB;
    wire       pulseA;
    wire       pulseB;
    wire [16:0] nextA;
    wire [16:0] nextB;
    wire       wrCtrl;
    wire       setA;
    wire       setB;

    assign runA = ctrlReg_q[`DTC_CTRL_RUN_A];
    assign runB = ctrlReg_q[`DTC_CTRL_RUN_B];

    // Shared divider; a zero prescale value ticks every cycle
    assign preTick = (preCnt_q == prescaleReg_q[`DTC_PRE_VALUE]);

    always @(posedge sys_clk) begin
        if (!reset_n) begin
            preCnt_q <= 4'h0;
        end else if (preTick) begin
            preCnt_q <= 4'h0;
        end else begin
            preCnt_q <= preCnt_q + 4'h1;
        end
    end

    // Pins: bits 0/1 count inputs, bits 2/3 gate inputs
    // Filtered level rises once stages two and three are both high, and falls as soon as they disagree
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            pinSync1_q <= 4'h0;
            pinSync2_q <= 4'h0;
            pinSync3_q <= 4'h0;
            pinFilt_q  <= 4'h0;
        end else begin
            pinSync1_q <= {gateInputB, gateInputA, countInputB, countInputA};
            pinSync2_q <= pinSync1_q;
            pinSync3_q <= pinSync2_q;
            pinFilt_q  <= (pinFilt_q & ~(pinSync2_q ^ pinSync3_q)) |
                          (pinSync2_q & ~(pinSync2_q ^ pinSync3_q));
        end
    end

    // Latch bits are already on this clock and need no synchroniser
    assign cntLevel = (PIN_COUNT != 0) ? pinFilt_q[1:0]
                                       : {port3LatchB, port3LatchA};

    always @(posedge sys_clk) begin
        if (!reset_n) begin
            cntPrev_q <= 2'h0;
        end else begin
            cntPrev_q <= cntLevel;
        end
    end

    // High sample then low sample; one level per cycle caps rate at half clock
    assign cntFall = cntPrev_q & ~cntLevel;

    // Gate pins double as crystal pins, so they gate only on the RC clock
    assign gateOkA = ~modeReg_q[`DTC_MODE_GATE_A] | ~prescaleReg_q[`DTC_PRE_RC_OSC] |
                     pinFilt_q[2];
    assign gateOkB = ~modeReg_q[`DTC_MODE_GATE_B] | ~prescaleReg_q[`DTC_PRE_RC_OSC] |
                     pinFilt_q[3];

    assign pulseA = runA & gateOkA &
                    (modeReg_q[`DTC_MODE_FUNC_A] ? cntFall[0] : preTick);
    assign pulseB = runB & gateOkB &
                    (modeReg_q[`DTC_MODE_FUNC_B] ? cntFall[1] : preTick);

    assign nextA = dtcStep(modeReg_q[`DTC_MODE_FIELD_A], ctrlRegB_q[`DTC_CTRLB_PSC_A],
                           cntHiA_q, cntLoA_q, rldHiA_q, rldLoA_q);
    assign nextB = dtcStep(modeReg_q[`DTC_MODE_FIELD_B], ctrlRegB_q[`DTC_CTRLB_PSC_B],
                           cntHiB_q, cntLoB_q, rldHiB_q, rldLoB_q);

    assign wrCtrl = regWrite & (regAddr == `DTC_OFS_CTRL);
    assign setA   = pulseA & nextA[16];
    assign setB   = pulseB & nextB[16];

    // Control register; hardware set beats a same-cycle clear
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            ctrlReg_q <= `DTC_RST_CTRL;
        end else begin
            if (wrCtrl) begin
                ctrlReg_q[`DTC_CTRL_RUN_A] <= regWrData[`DTC_CTRL_RUN_A];
                ctrlReg_q[`DTC_CTRL_RUN_B] <= regWrData[`DTC_CTRL_RUN_B];
            end
            if (setA) begin
                ctrlReg_q[`DTC_CTRL_OVF_A] <= 1'b1;
            end else if (intAckA) begin
                ctrlReg_q[`DTC_CTRL_OVF_A] <= 1'b0;
            end else if (wrCtrl) begin
                ctrlReg_q[`DTC_CTRL_OVF_A] <= regWrData[`DTC_CTRL_OVF_A];
            end
            if (setB) begin
                ctrlReg_q[`DTC_CTRL_OVF_B] <= 1'b1;
            end else if (intAckB) begin
                ctrlReg_q[`DTC_CTRL_OVF_B] <= 1'b0;
            end else if (wrCtrl) begin
                ctrlReg_q[`DTC_CTRL_OVF_B] <= regWrData[`DTC_CTRL_OVF_B];
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!reset_n) begin
            overflowFlagA_q <= 1'b0;
            overflowFlagB_q <= 1'b0;
        end else begin
            overflowFlagA_q <= setA | (~intAckA & ctrlReg_q[`DTC_CTRL_OVF_A] & ~wrCtrl) |
                               (~intAckA & wrCtrl & regWrData[`DTC_CTRL_OVF_A]);
            overflowFlagB_q <= setB | (~intAckB & ctrlReg_q[`DTC_CTRL_OVF_B] & ~wrCtrl) |
                               (~intAckB & wrCtrl & regWrData[`DTC_CTRL_OVF_B]);
        end
    end

    // Configuration and reload storage
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            modeReg_q     <= `DTC_RST_MODE;
            ctrlRegB_q    <= `DTC_RST_CTRL_B;
            prescaleReg_q <= `DTC_RST_PRESCALE;
            rldLoA_q      <= `DTC_RST_BYTE;
            rldHiA_q      <= `DTC_RST_BYTE;
            rldLoB_q      <= `DTC_RST_BYTE;
            rldHiB_q      <= `DTC_RST_BYTE;
        end else if (regWrite) begin
            case (regAddr)
                `DTC_OFS_MODE:     modeReg_q     <= regWrData;
                `DTC_OFS_CTRL_B:   ctrlRegB_q    <= regWrData;
                `DTC_OFS_PRESCALE: prescaleReg_q <= regWrData[4:0];
                `DTC_OFS_RLD_LO_A: rldLoA_q      <= regWrData;
                `DTC_OFS_RLD_HI_A: rldHiA_q      <= regWrData;
                `DTC_OFS_RLD_LO_B: rldLoB_q      <= regWrData;
                `DTC_OFS_RLD_HI_B: rldHiB_q      <= regWrData;
                default: begin
                end
            endcase
        end
    end

    // Count registers; a software write wins over a count in the same cycle
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            cntLoA_q <= `DTC_RST_BYTE;
            cntHiA_q <= `DTC_RST_BYTE;
        end else begin
            if (pulseA) begin
                cntHiA_q <= nextA[15:8];
                cntLoA_q <= nextA[7:0];
            end
            if (regWrite && regAddr == `DTC_OFS_CNT_LO_A) begin
                cntLoA_q <= regWrData;
            end
            if (regWrite && regAddr == `DTC_OFS_CNT_HI_A) begin
                cntHiA_q <= regWrData;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!reset_n) begin
            cntLoB_q <= `DTC_RST_BYTE;
            cntHiB_q <= `DTC_RST_BYTE;
        end else begin
            if (pulseB) begin
                cntHiB_q <= nextB[15:8];
                cntLoB_q <= nextB[7:0];
            end
            if (regWrite && regAddr == `DTC_OFS_CNT_LO_B) begin
                cntLoB_q <= regWrData;
            end
            if (regWrite && regAddr == `DTC_OFS_CNT_HI_B) begin
                cntHiB_q <= regWrData;
            end
        end
    end

    // Read data valid the cycle after the strobe only; zero otherwise
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            regRdData_q <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                `DTC_OFS_CTRL:     regRdData_q <= {ctrlReg_q[7:4], 4'h0};
                `DTC_OFS_MODE:     regRdData_q <= modeReg_q;
                `DTC_OFS_CNT_LO_A: regRdData_q <= cntLoA_q;
                `DTC_OFS_CNT_LO_B: regRdData_q <= cntLoB_q;
                `DTC_OFS_CNT_HI_A: regRdData_q <= cntHiA_q;
                `DTC_OFS_CNT_HI_B: regRdData_q <= cntHiB_q;
                `DTC_OFS_CTRL_B:   regRdData_q <= ctrlRegB_q;
                `DTC_OFS_RLD_LO_A: regRdData_q <= rldLoA_q;
                `DTC_OFS_RLD_LO_B: regRdData_q <= rldLoB_q;
                `DTC_OFS_RLD_HI_A: regRdData_q <= rldHiA_q;
                `DTC_OFS_RLD_HI_B: regRdData_q <= rldHiB_q;
                `DTC_OFS_PRESCALE: regRdData_q <= {3'h0, prescaleReg_q};
                default:           regRdData_q <= 8'h00;
            endcase
        end else begin
            regRdData_q <= 8'h00;
        end
    end

endmodule

//--- bench/dtc_timer_sva.sv
// Purpose: Port-level checks of the dual timer/counter
// Assumes: Bound to dtc_timer, single clock domain
// Notes:   Counting itself is judged by the bench
`timescale 1ns/1ps
module dtc_timer_sva (
    input wire       sys_clk,
    input wire       reset_n,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire       regWrite,
    input wire       regRead,
    input wire [7:0] regRdData_q,
    input wire       intAckA,
    input wire       intAckB,
    input wire       overflowFlagA_q,
    input wire       overflowFlagB_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence wrRd(a);
        regWrite && regAddr == a ##1 regRead && regAddr == a;
    endsequence
    property readBack(a);
        wrRd(a) |=> regRdData_q == $past(regWrData, 2);
    endproperty
    // Read data only stands in the cycle after a read strobe
    AST_RD_IDLE: assert property (!regRead |=> regRdData_q == 8'h00)
        else $error("read data not zero outside read cycle");
    AST_UNMAPPED: assert property (regRead && regAddr > 8'h96 |=> regRdData_q == 8'h00)
        else $error("unmapped read not zero");
    AST_CTRL_A: assert property (regRead && regAddr == 8'h88 |=>
        regRdData_q[5] == $past(overflowFlagA_q) && regRdData_q[3:0] == 4'h0)
        else $error("control read disagrees with flag A");
    AST_CTRL_B: assert property (regRead && regAddr == 8'h88 |=>
        regRdData_q[7] == $past(overflowFlagB_q))
        else $error("control read disagrees with flag B");
    AST_MODE_RB: assert property (readBack(8'h89))
        else $error("mode register readback wrong");
    AST_CTRLB_RB: assert property (readBack(8'h91))
        else $error("control B readback wrong");
    AST_RLD_RB: assert property (readBack(8'h92))
        else $error("reload readback wrong");
    AST_HOLD_A: assert property (overflowFlagA_q && !intAckA &&
        !(regWrite && regAddr == 8'h88) |=> overflowFlagA_q)
        else $error("flag A dropped without cause");
    AST_HOLD_B: assert property (overflowFlagB_q && !intAckB &&
        !(regWrite && regAddr == 8'h88) |=> overflowFlagB_q)
        else $error("flag B dropped without cause");
    cover property ($rose(overflowFlagA_q));
    cover property ($rose(overflowFlagB_q));
    cover property (intAckA && overflowFlagA_q);
endmodule

bind dtc_timer dtc_timer_sva chk_u (.sys_clk, .reset_n, .regAddr, .regWrData, .regWrite,
    .regRead, .regRdData_q, .intAckA, .intAckB, .overflowFlagA_q, .overflowFlagB_q);

//--- bench/dtc_pin_model.sv
// Purpose: External count and gate pin source
// Assumes: Driven from the bench through tasks
// Notes:   Count pins idle high; chB picks channel B, else channel A
`timescale 1ns/1ps
module dtc_pin_model (
    input  wire sys_clk,
    output reg  countInputA,
    output reg  countInputB,
    output reg  gateInputA,
    output reg  gateInputB
);
    initial begin
        countInputA = 1'b1;
        countInputB = 1'b1;
        gateInputA = 1'b0;
        gateInputB = 1'b1;
    end
    // Pin filter wants two agreeing high samples before it rises; each level is held two cycles
    task pulses(input int n, input bit chB);
        repeat (n) begin
            @(posedge sys_clk);
            countInputA <= chB;
            countInputB <= !chB;
            repeat (2) @(posedge sys_clk);
            countInputA <= 1'b1;
            countInputB <= 1'b1;
            @(posedge sys_clk);
        end
    endtask
    task gate(input bit chB, input logic g);
        @(posedge sys_clk);
        gateInputA <= chB ? gateInputA : g;
        gateInputB <= chB ? g : gateInputB;
    endtask
endmodule

//--- bench/dtc_timer_tb_top.sv
// Purpose: Register-level regression of the dual timer/counter
// Assumes: Pin count inputs (PIN_COUNT 1), port latches unused
// Notes:   A write strobe stays up until the next rd or idle call
`timescale 1ns/1ps
`include "dtc_map.vh"
module dtc_timer_tb_top;
    reg        sys_clk;
    reg        reset_n;
    reg  [7:0] regAddr;
    reg  [7:0] regWrData;
    reg        regWrite;
    reg        regRead;
    reg        intAckA;
    reg        intAckB;
    reg        port3LatchA;
    reg        port3LatchB;
    wire [7:0] regRdData_q;
    wire       countInputA;
    wire       countInputB;
    wire       gateInputA;
    wire       gateInputB;
    wire       overflowFlagA_q;
    wire       overflowFlagB_q;
    int        badCount;
    int        nTests;
    int        cycles;
    logic [7:0] rstAddr [14] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h91,
                                 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h80, 8'h97};

    dtc_timer dut_u (.sys_clk, .reset_n, .regAddr, .regWrData, .regWrite, .regRead,
        .regRdData_q, .countInputA, .countInputB, .gateInputA, .gateInputB,
        .port3LatchA, .port3LatchB, .intAckA, .intAckB,
        .overflowFlagA_q, .overflowFlagB_q);
    dtc_pin_model pins_u (.sys_clk, .countInputA, .countInputB, .gateInputA, .gateInputB);

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        nTests++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regRead <= 1'b0;
        regAddr <= a;
        regWrData <= d;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regWrite <= 1'b0;
        regAddr <= a;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        check($sformatf("reg %h", a), exp, regRdData_q & msk);
    endtask
    task ack(input bit chB);
        @(posedge sys_clk);
        intAckA <= !chB;
        intAckB <= chB;
        @(posedge sys_clk);
        intAckA <= 1'b0;
        intAckB <= 1'b0;
        #1;
    endtask
    task idle(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            regWrite <= 1'b0;
            regRead <= 1'b0;
        end
    endtask
    task giveVerdict;
        $display("Checks %0d mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            badCount++;
            giveVerdict();
        end
    end

    initial begin
        {reset_n, regAddr, regWrData, regWrite, regRead, intAckA, intAckB} = '0;
        {port3LatchA, port3LatchB} = 2'h3;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 14; i++)
            rd(rstAddr[i], rstAddr[i] == 8'h91 ? `DTC_RST_CTRL_B : 8'h00, 8'hFF);
        wr(`DTC_OFS_MODE, 8'hA5);
        rd(`DTC_OFS_MODE, 8'hA5, 8'hFF);
        wr(`DTC_OFS_CTRL_B, 8'hE4);
        rd(`DTC_OFS_CTRL_B, 8'hE4, 8'hFF);
        wr(`DTC_OFS_RLD_LO_A, 8'h5A);
        rd(`DTC_OFS_RLD_LO_A, 8'h5A, 8'hFF);
        // Mode 2 timer A, six counts across one reload
        wr(`DTC_OFS_MODE, 8'h02);
        wr(`DTC_OFS_CNT_HI_A, 8'hF0);
        wr(`DTC_OFS_CNT_LO_A, 8'hFC);
        wr(`DTC_OFS_CTRL, 8'h10);
        idle(5);
        #1;
        check("flagA", 8'h01, {7'h0, overflowFlagA_q});
        // Stop with the flag bit written as one so the flag survives
        wr(`DTC_OFS_CTRL, 8'h20);
        idle(1);
        rd(`DTC_OFS_CNT_LO_A, 8'hF2, 8'hFF);
        rd(`DTC_OFS_CNT_HI_A, 8'hF0, 8'hFF);
        ack(1'b0);
        check("flagA ack", 8'h00, {7'h0, overflowFlagA_q});
        // Mode 0 timer A, 13-bit after reset field value
        wr(`DTC_OFS_MODE, 8'h00);
        wr(`DTC_OFS_CNT_HI_A, 8'hFF);
        wr(`DTC_OFS_CNT_LO_A, 8'hFE);
        wr(`DTC_OFS_CTRL, 8'h10);
        idle(3);
        #1;
        check("flagA m0", 8'h01, {7'h0, overflowFlagA_q});
        wr(`DTC_OFS_CTRL, 8'h00);
        rd(`DTC_OFS_CNT_LO_A, 8'h02, 8'h1F);
        rd(`DTC_OFS_CNT_HI_A, 8'h00, 8'hFF);
        // Mode 1 timer B, prescale 1: a tick every second cycle
        wr(`DTC_OFS_PRESCALE, 8'h01);
        wr(`DTC_OFS_MODE, 8'h10);
        wr(`DTC_OFS_CNT_LO_B, 8'hFE);
        wr(`DTC_OFS_CNT_HI_B, 8'hFF);
        wr(`DTC_OFS_RLD_LO_B, 8'h34);
        wr(`DTC_OFS_RLD_HI_B, 8'h12);
        wr(`DTC_OFS_CTRL, 8'h40);
        idle(7);
        #1;
        check("flagB", 8'h01, {7'h0, overflowFlagB_q});
        wr(`DTC_OFS_CTRL, 8'h80);
        rd(`DTC_OFS_CNT_LO_B, 8'h36, 8'hFF);
        rd(`DTC_OFS_CNT_HI_B, 8'h12, 8'hFF);
        ack(1'b1);
        check("flagB ack", 8'h00, {7'h0, overflowFlagB_q});
        // Counter A, gated by pin under the RC oscillator
        wr(`DTC_OFS_PRESCALE, 8'h10);
        wr(`DTC_OFS_MODE, 8'h0E);
        wr(`DTC_OFS_CNT_HI_A, 8'h00);
        wr(`DTC_OFS_CNT_LO_A, 8'h00);
        wr(`DTC_OFS_CTRL, 8'h10);
        idle(1);
        pins_u.pulses(3, 1'b0);
        idle(8);
        rd(`DTC_OFS_CNT_LO_A, 8'h00, 8'hFF);
        pins_u.gate(1'b0, 1'b1);
        pins_u.pulses(3, 1'b0);
        idle(8);
        rd(`DTC_OFS_CNT_LO_A, 8'h03, 8'hFF);
        wr(`DTC_OFS_PRESCALE, 8'h00);
        idle(1);
        pins_u.gate(1'b0, 1'b0);
        pins_u.pulses(2, 1'b0);
        idle(8);
        rd(`DTC_OFS_CNT_LO_A, 8'h05, 8'hFF);
        wr(`DTC_OFS_MODE, 8'h07);
        idle(1);
        pins_u.pulses(2, 1'b0);
        idle(8);
        rd(`DTC_OFS_CNT_LO_A, 8'h05, 8'hFF);
        // Counter B in mode 2, then held off by its own gate pin
        wr(`DTC_OFS_MODE, 8'h60);
        wr(`DTC_OFS_CNT_LO_B, 8'h00);
        wr(`DTC_OFS_CTRL, 8'h40);
        idle(1);
        pins_u.pulses(2, 1'b1);
        idle(8);
        rd(`DTC_OFS_CNT_LO_B, 8'h02, 8'hFF);
        wr(`DTC_OFS_PRESCALE, 8'h10);
        wr(`DTC_OFS_MODE, 8'hE0);
        idle(1);
        pins_u.gate(1'b1, 1'b0);
        pins_u.pulses(2, 1'b1);
        idle(8);
        rd(`DTC_OFS_CNT_LO_B, 8'h02, 8'hFF);
        giveVerdict();
    end
endmodule
